// ===== src/prbs_checker_params.svh
// Register offsets, field positions, reset values and counts of the sequence error checker
`ifndef PRBS_CHECKER_PARAMS_SVH
`define PRBS_CHECKER_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_TOTAL_LIMIT 8'h0c
`define OFS_ERROR_LIMIT 8'h10
`define OFS_TOTAL_COUNT 8'h14
`define OFS_ERROR_COUNT 8'h18
`define OFS_RESULT_INFO 8'h1c

// ==========================================================
// Control register fields
`define CTRL_RUN_BIT      0
`define CTRL_POLY_LSB     1
`define CTRL_POLY_MSB     3
`define CTRL_QUAL_EN_BIT  4
`define CTRL_QUAL_POL_BIT 5
`define CTRL_INTEG_BIT    6
`define CTRL_MODESEL_BIT  7

// ==========================================================
// Status and mask fields (same layout)
`define STAT_DONE_BIT 0
`define STAT_DISC_BIT 1
`define STAT_SYNC_BIT 2
`define STAT_W        3

// ==========================================================
// Result info fields
`define INFO_DONE_BIT     0
`define INFO_END_TOT_BIT  1
`define INFO_END_ERR_BIT  2
`define INFO_SYNCED_BIT   3
`define INFO_CLK_ACT_BIT  4
`define INFO_DATA_ACT_BIT 5
`define INFO_CFG_BIT      6
`define INFO_BAD_BIT      7

// ==========================================================
// Reset values and counts
`define TOTAL_LIMIT_RST 32'hffff_ffff
`define ERROR_LIMIT_RST 32'hffff_ffff
`define BAD_MIN_BITS    32'h0000_0040
`define ACT_TIMEOUT_CYC 16'h0100

`endif

// ===== src/prbs_checker_pkg.sv
// Types shared by the sequence error checker and its pin synchroniser
`include "prbs_checker_params.svh"
package prbs_checker_pkg;

	// ==========================================================
	// Polynomial selection codes
	typedef enum logic [2:0] {
		POLY_PN9  = 3'b000,
		POLY_PN11 = 3'b001,
		POLY_PN15 = 3'b010,
		POLY_PN16 = 3'b011,
		POLY_PN20 = 3'b100,
		POLY_PN21 = 3'b101,
		POLY_PN23 = 3'b110
	} poly_e;

	// ==========================================================
	// Measurement states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_RUN  = 2'b10,
		ST_DONE = 2'b11
	} meas_state_e;

	// ==========================================================
	// Pin synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} pin_sync_s;

	// ==========================================================
	// Checker state
	typedef struct packed {
		meas_state_e         state;
		logic [22:0]         seq;
		logic [4:0]          fill_cnt;
		logic [31:0]         total;
		logic [31:0]         errs;
		logic [31:0]         total_limit;
		logic [31:0]         error_limit;
		logic                end_tot;
		logic                end_err;
		logic                run_en;
		logic [2:0]          poly;
		logic                qual_en;
		logic                qual_pol;
		logic                integ;
		logic                mode_req;
		logic                cfg_loaded;
		logic                boot_done;
		logic [`STAT_W-1:0]  status;
		logic [`STAT_W-1:0]  mask;
		logic                clk_prev;
		logic [15:0]         clk_act_cnt;
		logic [15:0]         data_act_cnt;
		logic                data_prev;
		logic [31:0]         rdata;
	} checker_s;

endpackage

// ===== src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync
	import prbs_checker_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level_out
);

	pin_sync_s r_reg;
	pin_sync_s r_next;

	// ==========================================================
	// Next state: the level follows only when stages two and three agree
	always_comb begin
		r_next = r_reg;
		r_next.s1 = pin_in;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3) begin
			r_next.level = r_reg.s3;
		end
	end

	// Register, synchronous reset to all zero
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign level_out = r_reg.level;

endmodule

// ===== src/prbs_bit_error_checker.sv
// Self-synchronising pseudo-random sequence bit error checker with register port
//
// Behaviour
// [R01] After a measurement ends, no new one starts until the result is queried.
// [R02] After restart following a query, sync is regained within 24 received bits.
// [R03] Sync loads received bits into the sequence register, degree bits long.
// [R04] Results with about half the bits faulty are discarded, restarting at query; the code discards from a quarter faulty.
// [R05] Selecting a polynomial applies its prescribed inversion automatically.
// [R06] Feedback uses the selected polynomial; wrong polynomial or polarity fails sync.
// [R07] A supplied bit clock gives one rising edge per data bit evaluated.
// [R08] A sequence break without restart control shows about half the bits faulty.
// [R09] For a discontinuous sequence the far side pulses restart each repetition.
// [R10] Clock and data line activity is reported per line to the host.
// [R11] Mode selection is stored and applies at next power cycle before measuring.
// [R12] With qualifier enabled, bits are checked only while it has its active level.
// [R13] In integrating mode restart high holds the measurement, low lets it run.
// [R14] 32-bit total and error counters; first limit reached ends, criterion reported.
// [R15] Degrees 9, 11, 15, 16, 20, 21, 23; degrees 15 and 23 inverted.
`timescale 1ns/1ns
module prbs_bit_error_checker
	import prbs_checker_pkg::*;
#(
	parameter logic [15:0] ACT_TIMEOUT = `ACT_TIMEOUT_CYC,
	parameter int          COUNT_W     = 32
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	input  wire logic        bit_clk_in,
	input  wire logic        data_in,
	input  wire logic        data_valid_qualifier,
	input  wire logic        sequence_restart_input,
	input  wire logic        mode_stored,
	output logic             mode_store_req
);

	`include "prbs_checker_params.svh"

	// ==========================================================
	// Elaboration checks
	// Counters are fixed at 32 bits; any other width would break the limit compares
	if (COUNT_W != 32) begin : g_bad_count_w
		$error("prbs_bit_error_checker: COUNT_W must be 32");
	end
	// A window under two cycles shows a line as active for one cycle per change at most
	if (ACT_TIMEOUT < 16'h0002) begin : g_bad_act_window
		$error("prbs_bit_error_checker: ACT_TIMEOUT too small");
	end

	// ==========================================================
	// Polynomial helpers

	// Degree of the selected polynomial; unknown codes fall back to degree nine
	function automatic logic [4:0] poly_degree(input logic [2:0] sel);
		case (sel)
			POLY_PN9:  poly_degree = 5'h09;
			POLY_PN11: poly_degree = 5'h0b;
			POLY_PN15: poly_degree = 5'h0f;
			POLY_PN16: poly_degree = 5'h10;
			POLY_PN20: poly_degree = 5'h14;
			POLY_PN21: poly_degree = 5'h15;
			POLY_PN23: poly_degree = 5'h17;
			default:   poly_degree = 5'h09;
		endcase
	endfunction

	// Inversion prescribed by the sequence standard
	function automatic logic poly_inverted(input logic [2:0] sel);
		case (sel)
			POLY_PN15: poly_inverted = 1'b1; // R05 R15
			POLY_PN23: poly_inverted = 1'b1; // R05 R15
			default:   poly_inverted = 1'b0;
		endcase
	endfunction

	// Feedback bit; seq[0] holds the newest bit
	function automatic logic poly_feedback(input logic [2:0] sel, input logic [22:0] s);
		case (sel)
			POLY_PN9:  poly_feedback = s[8] ^ s[3];                  // R06
			POLY_PN11: poly_feedback = s[10] ^ s[1];                 // R06
			POLY_PN15: poly_feedback = s[14] ^ s[0];                 // R06
			POLY_PN16: poly_feedback = s[15] ^ s[4] ^ s[2] ^ s[1];   // R06
			POLY_PN20: poly_feedback = s[19] ^ s[2];                 // R06
			POLY_PN21: poly_feedback = s[20] ^ s[1];                 // R06
			POLY_PN23: poly_feedback = s[22] ^ s[4];                 // R06
			default:   poly_feedback = s[8] ^ s[3];
		endcase
	endfunction

	// A result is bad when at least a quarter of enough bits are faulty
	function automatic logic bad_ratio(input logic [31:0] tot, input logic [31:0] er);
		bad_ratio = (tot >= `BAD_MIN_BITS) && ({er, 2'b00} >= {2'b00, tot}); // R04
	endfunction

	// Idle-time counter for an activity monitor, saturating at the timeout
	function automatic logic [15:0] act_step(input logic changed, input logic [15:0] cnt,
	                                         input logic [15:0] lim);
		if (changed) begin
			act_step = 16'h0000;
		end else if (cnt < lim) begin
			act_step = cnt + 16'h0001;
		end else begin
			act_step = cnt;
		end
	endfunction

	// ==========================================================
	// Pin synchronisers for the bit clock, data, qualifier and restart lines from outside the clock domain
	logic [3:0] pins_raw;
	logic [3:0] pins_f;

	assign pins_raw = {sequence_restart_input, data_valid_qualifier, data_in, bit_clk_in};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			pin_sync u_sync (
				.clk_sys   (clk_sys),
				.rst_b     (rst_b),
				.pin_in    (pins_raw[gi]),
				.level_out (pins_f[gi])
			);
		end
	endgenerate

	// ==========================================================
	// State
	checker_s r_reg;
	checker_s r_next;

	localparam checker_s RESET_STATE = '{
		state:        ST_IDLE,
		seq:          23'h000000,
		fill_cnt:     5'h00,
		total:        32'h0000_0000,
		errs:         32'h0000_0000,
		total_limit:  `TOTAL_LIMIT_RST,
		error_limit:  `ERROR_LIMIT_RST,
		end_tot:      1'b0,
		end_err:      1'b0,
		run_en:       1'b0,
		poly:         3'h0,
		qual_en:      1'b0,
		qual_pol:     1'b1,
		integ:        1'b0,
		mode_req:     1'b0,
		cfg_loaded:   1'b0,
		boot_done:    1'b0,
		status:       3'h0,
		mask:         3'h0,
		clk_prev:     1'b0,
		clk_act_cnt:  ACT_TIMEOUT,
		data_act_cnt: ACT_TIMEOUT,
		data_prev:    1'b0,
		rdata:        32'h0000_0000
	};

	// ==========================================================
	// Combinational next-state
	logic              bit_edge;
	logic              qual_ok;
	logic              rx_bit;
	logic              exp_bit;
	logic              hold;
	logic              run_ok;
	logic              query;
	logic              bad_now;
	logic              clk_active;
	logic              data_active;
	logic [31:0]       tot_inc;
	logic [31:0]       err_inc;
	logic [4:0]        degree;
	logic [`STAT_W-1:0] ev;
	logic [`STAT_W-1:0] clr;
	logic [31:0]       info;
	logic [31:0]       rd_mux;

	always_comb begin
		r_next = r_reg;
		ev = '0;
		clr = '0;
		degree = poly_degree(r_reg.poly);
		bit_edge = pins_f[0] & ~r_reg.clk_prev; // R07
		qual_ok = !r_reg.qual_en || (pins_f[2] == r_reg.qual_pol); // R12
		rx_bit = pins_f[1] ^ poly_inverted(r_reg.poly); // R05
		exp_bit = poly_feedback(r_reg.poly, r_reg.seq); // R06
		hold = r_reg.integ && pins_f[3]; // R13
		run_ok = r_reg.run_en && r_reg.cfg_loaded; // R11
		query = reg_rd && (reg_addr == `OFS_RESULT_INFO);
		bad_now = bad_ratio(r_reg.total, r_reg.errs);
		tot_inc = r_reg.total + 32'h0000_0001;
		err_inc = r_reg.errs + {31'h0000_0000, rx_bit != exp_bit};
		clk_active = r_reg.clk_act_cnt < ACT_TIMEOUT;
		data_active = r_reg.data_act_cnt < ACT_TIMEOUT;

		// Line edge history and activity monitors
		r_next.clk_prev = pins_f[0];
		r_next.data_prev = pins_f[1];
		r_next.clk_act_cnt = act_step(pins_f[0] != r_reg.clk_prev,
		                              r_reg.clk_act_cnt, ACT_TIMEOUT); // R10
		r_next.data_act_cnt = act_step(pins_f[1] != r_reg.data_prev,
		                               r_reg.data_act_cnt, ACT_TIMEOUT); // R10

		// Stored mode is caught once, in the first cycle after reset release
		if (!r_reg.boot_done) begin
			r_next.boot_done = 1'b1;
			r_next.cfg_loaded = mode_stored; // R11
		end

		// Measurement sequencer
		case (r_reg.state)
			ST_IDLE: begin
				if (run_ok && !hold) begin
					r_next.state = ST_FILL;
					r_next.fill_cnt = 5'h00;
					r_next.total = 32'h0000_0000;
					r_next.errs = 32'h0000_0000;
					r_next.end_tot = 1'b0;
					r_next.end_err = 1'b0;
				end
			end
			ST_FILL: begin
				if (!run_ok) begin
					r_next.state = ST_IDLE;
				end else if (hold) begin
					r_next.fill_cnt = 5'h00; // R13
				end else if (bit_edge && qual_ok) begin
					r_next.seq = {r_reg.seq[21:0], rx_bit}; // R03
					r_next.fill_cnt = r_reg.fill_cnt + 5'h01;
					if (r_reg.fill_cnt + 5'h01 >= degree) begin
						r_next.state = ST_RUN; // R02 R03
						ev[`STAT_SYNC_BIT] = 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (!run_ok) begin
					r_next.state = ST_IDLE;
				end else if (hold) begin
					// Integrating mode keeps the counts and reloads on release
					r_next.state = ST_FILL; // R13
					r_next.fill_cnt = 5'h00;
				end else if (bit_edge && qual_ok) begin
					r_next.seq = {r_reg.seq[21:0], exp_bit}; // R06 R08
					r_next.total = tot_inc; // R14
					r_next.errs = err_inc; // R14
					if (tot_inc >= r_reg.total_limit || err_inc >= r_reg.error_limit) begin
						r_next.state = ST_DONE; // R14
						r_next.end_tot = tot_inc >= r_reg.total_limit;
						r_next.end_err = err_inc >= r_reg.error_limit;
						ev[`STAT_DONE_BIT] = 1'b1;
					end
				end
			end
			ST_DONE: begin
				// Only the query releases a finished measurement
				if (query) begin
					if (bad_now) begin
						ev[`STAT_DISC_BIT] = 1'b1; // R04
					end
					r_next.state = run_ok ? ST_FILL : ST_IDLE; // R01 R02
					r_next.fill_cnt = 5'h00;
					r_next.total = 32'h0000_0000;
					r_next.errs = 32'h0000_0000;
					r_next.end_tot = 1'b0;
					r_next.end_err = 1'b0;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`OFS_CTRL: begin
					r_next.run_en = reg_wdata[`CTRL_RUN_BIT];
					r_next.poly = reg_wdata[`CTRL_POLY_MSB:`CTRL_POLY_LSB];
					r_next.qual_en = reg_wdata[`CTRL_QUAL_EN_BIT];
					r_next.qual_pol = reg_wdata[`CTRL_QUAL_POL_BIT];
					r_next.integ = reg_wdata[`CTRL_INTEG_BIT];
					if (reg_wdata[`CTRL_MODESEL_BIT]) begin
						r_next.mode_req = 1'b1; // R11
					end
				end
				`OFS_STATUS:      clr = reg_wdata[`STAT_W-1:0];
				`OFS_MASK:        r_next.mask = reg_wdata[`STAT_W-1:0];
				`OFS_TOTAL_LIMIT: r_next.total_limit = reg_wdata;
				`OFS_ERROR_LIMIT: r_next.error_limit = reg_wdata;
				default: begin
				end
			endcase
		end

		// Sticky status: a new event wins over a clear in the same cycle
		r_next.status = (r_reg.status & ~clr) | ev;

		// Result information word
		info = 32'h0000_0000;
		info[`INFO_DONE_BIT] = r_reg.state == ST_DONE;
		info[`INFO_END_TOT_BIT] = r_reg.end_tot; // R14
		info[`INFO_END_ERR_BIT] = r_reg.end_err; // R14
		info[`INFO_SYNCED_BIT] = (r_reg.state == ST_RUN || r_reg.state == ST_DONE) && !bad_now;
		info[`INFO_CLK_ACT_BIT] = clk_active; // R10
		info[`INFO_DATA_ACT_BIT] = data_active; // R10
		info[`INFO_CFG_BIT] = r_reg.cfg_loaded;
		info[`INFO_BAD_BIT] = bad_now; // R04

		// Read multiplexer; unmapped offsets read zero
		case (reg_addr)
			`OFS_CTRL: rd_mux = {24'h000000, r_reg.mode_req, r_reg.integ, r_reg.qual_pol,
			                    r_reg.qual_en, r_reg.poly, r_reg.run_en};
			`OFS_STATUS:      rd_mux = {29'h00000000, r_reg.status};
			`OFS_MASK:        rd_mux = {29'h00000000, r_reg.mask};
			`OFS_TOTAL_LIMIT: rd_mux = r_reg.total_limit;
			`OFS_ERROR_LIMIT: rd_mux = r_reg.error_limit;
			`OFS_TOTAL_COUNT: rd_mux = r_reg.total;
			`OFS_ERROR_COUNT: rd_mux = r_reg.errs;
			`OFS_RESULT_INFO: rd_mux = info;
			default:          rd_mux = 32'h0000_0000;
		endcase

		// Read data stand only in the cycle after the strobe
		r_next.rdata = reg_rd ? rd_mux : 32'h0000_0000;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = r_reg.rdata;
	assign irq = |(r_reg.status & r_reg.mask);
	assign mode_store_req = r_reg.mode_req;

endmodule

// ===== dv/prbs_bit_error_checker_sva.sv
// Port-level assertions of the sequence error checker
`timescale 1ns/1ns
`include "prbs_checker_params.svh"
module prbs_bit_error_checker_sva
	import prbs_checker_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        irq,
	input wire logic        bit_clk_in,
	input wire logic        data_in,
	input wire logic        data_valid_qualifier,
	input wire logic        sequence_restart_input,
	input wire logic        mode_stored,
	input wire logic        mode_store_req
);
	logic [2:0] mask_q;
	logic       boot_q;
	logic       cfg_q;
	logic       mode_wr_q;

	// ==========
	// Shadows of what software wrote and what the strap gave at boot
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mask_q    <= 3'h0;
			boot_q    <= 1'b1;
			cfg_q     <= 1'b0;
			mode_wr_q <= 1'b0;
		end else begin
			boot_q    <= 1'b0;
			mode_wr_q <= reg_wr && reg_addr == `OFS_CTRL && reg_wdata[7];
			if (boot_q)
				cfg_q <= mode_stored;
			if (reg_wr && reg_addr == `OFS_MASK)
				mask_q <= reg_wdata[2:0];
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// ==========
	// Bus steps
	sequence s_rd_info;
		reg_rd && reg_addr == `OFS_RESULT_INFO;
	endsequence
	sequence s_rd_stat;
		reg_rd && reg_addr == `OFS_STATUS;
	endsequence
	sequence s_mode_wr;
		reg_wr && reg_addr == `OFS_CTRL && reg_wdata[7];
	endsequence
	sequence s_lim_wr_rd;
		reg_wr && reg_addr == `OFS_TOTAL_LIMIT ##1 reg_rd && reg_addr == `OFS_TOTAL_LIMIT;
	endsequence

	// ==========
	// Properties
	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	property p_limit_rw;
		s_lim_wr_rd |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	property p_cfg;
		s_rd_info |=> reg_rdata[6] == cfg_q;
	endproperty
	property p_store_set;
		s_mode_wr |=> mode_store_req;
	endproperty
	property p_store_keep;
		mode_store_req |=> mode_store_req;
	endproperty
	property p_store_cause;
		$rose(mode_store_req) |-> mode_wr_q;
	endproperty
	property p_irq_mask;
		mask_q == 3'h0 |-> !irq;
	endproperty
	property p_irq_stat;
		s_rd_stat ##1 (reg_rdata[2:0] & mask_q) != 3'h0 |-> irq;
	endproperty
	property p_irq_hold;
		irq && !reg_wr |=> irq;
	endproperty

	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read slot");
	a_limit_rw: assert property (p_limit_rw)
		else $error("total limit readback wrong");
	a_cfg: assert property (p_cfg)
		else $error("config flag wrong");
	a_store_set: assert property (p_store_set)
		else $error("store request not raised");
	a_store_keep: assert property (p_store_keep)
		else $error("store request dropped");
	a_store_cause: assert property (p_store_cause)
		else $error("store request without write");
	a_irq_mask: assert property (p_irq_mask)
		else $error("irq with mask clear");
	a_irq_stat: assert property (p_irq_stat)
		else $error("irq low with unmasked status");
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq dropped without write");
endmodule

// ===== dv/prbs_link_model.sv
// Far-side model: bit clock, sequence data, qualifier and restart
`timescale 1ns/1ns
module prbs_link_model
	import prbs_checker_pkg::*;
(
	output logic bit_clk,
	output logic data,
	output logic qual,
	output logic restart
);
	logic [22:0] st;

	initial begin
		bit_clk = 1'b0;
		data    = 1'b0;
		qual    = 1'b0;
		restart = 1'b0;
		st      = '1;
	end

	// ==========
	// Generator feedback, written apart from the checker's own
	function automatic logic fb(input poly_e p, input logic [22:0] s);
		case (p)
			POLY_PN11: return s[10] ^ s[1];
			POLY_PN15: return s[14] ^ s[0];
			POLY_PN16: return s[15] ^ s[4] ^ s[2] ^ s[1];
			POLY_PN20: return s[19] ^ s[2];
			POLY_PN21: return s[20] ^ s[1];
			POLY_PN23: return s[22] ^ s[4];
			default:   return s[8] ^ s[3];
		endcase
	endfunction

	// One rising edge per bit; 320 ns period
	task automatic pulse();
		#80 bit_clk = 1'b1;
		#160 bit_clk = 1'b0;
		#80;
	endtask

	// Frame of n bits; gap_at puts four junk bits with qualifier low
	task automatic send(input poly_e p, input int n, input bit flip, input int err_at,
			input int gap_at);
		logic b;
		logic inv;
		inv = (p == POLY_PN15) || (p == POLY_PN23);
		#13;
		for (int i = 0; i < n; i++) begin
			if (i == gap_at) begin
				qual = 1'b0;
				repeat (4) begin
					data = ~(fb(p, st) ^ inv);
					pulse();
				end
			end
			b    = fb(p, st);
			st   = {st[21:0], b};
			data = b ^ inv ^ flip ^ (i == err_at);
			qual = 1'b1;
			pulse();
		end
		// Released lines must not keep the last bit, so show its inverse
		data = ~data;
		qual = 1'b0;
		#320;
	endtask

	// Restart pulse, then the sequence begins again from its start
	task automatic restart_seq();
		restart = 1'b1;
		#640 restart = 1'b0;
		#320 st = '1;
	endtask
endmodule

// ===== dv/prbs_bit_error_checker_tb_top.sv
// Self-checking bench of the sequence error checker
`timescale 1ns/1ns
`include "prbs_checker_params.svh"
module prbs_bit_error_checker_tb_top
	import prbs_checker_pkg::*;
;
	logic        clk_sys;
	logic        rst_b;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        bit_clk_in;
	logic        data_in;
	logic        qual;
	logic        restart;
	logic        mode_stored;
	logic        mode_store_req;
	int          err_total;
	int          check_count;
	int          deg [7] = '{9, 11, 15, 16, 20, 21, 23};

	// Short activity window keeps idle checks quick
	prbs_bit_error_checker #(.ACT_TIMEOUT(16'h0010), .COUNT_W(32)) dut_u (
		.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.bit_clk_in(bit_clk_in), .data_in(data_in), .data_valid_qualifier(qual),
		.sequence_restart_input(restart), .mode_stored(mode_stored),
		.mode_store_req(mode_store_req));
	prbs_link_model lk_u (.bit_clk(bit_clk_in), .data(data_in), .qual(qual),
		.restart(restart));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ==========
	// Bus access and comparison
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= w;
		reg_rd    <= r;
		reg_addr  <= a;
		reg_wdata <= d;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, 32'h0);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, 1'b1, a, 32'h0);
		bus(1'b0, 1'b0, a, 32'h0);
		check_count++;
		if ((reg_rdata & m) !== e) begin
			err_total++;
			$display("[ERR] %0t reg %h got %h want %h", $time, a, reg_rdata & m, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t pin got %b want %b", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, about five times the expected run
	initial begin
		#2000000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end

	// ==========
	// Scenarios
	initial begin
		err_total   = 0;
		check_count = 0;
		rst_b       = 1'b0;
		mode_stored = 1'b1;
		reg_addr    = 8'h0;
		reg_wdata   = 32'h0;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		rchk(`OFS_CTRL, 32'h20, '1);
		rchk(`OFS_TOTAL_LIMIT, `TOTAL_LIMIT_RST, '1);
		rchk(`OFS_ERROR_LIMIT, `ERROR_LIMIT_RST, '1);
		rchk(8'h20, 32'h0, '1);
		rchk(`OFS_RESULT_INFO, 32'h40, '1);
		bus(1'b1, 1'b0, `OFS_TOTAL_LIMIT, 32'd40);
		rchk(`OFS_TOTAL_LIMIT, 32'd40, '1);
		// Every polynomial, twice so the second run starts from the query
		for (int p = 0; p < 7; p++) begin
			wr(`OFS_CTRL, 32'h0);
			wr(`OFS_CTRL, 32'h31 + 32'(2 * p));
			for (int k = 0; k < 2; k++) begin
				wr(`OFS_STATUS, 32'h7);
				lk_u.send(poly_e'(p), deg[p] + 40, 1'b0, deg[p] + 3, deg[p] + 6);
				rchk(`OFS_STATUS, 32'h5, '1);
				rchk(`OFS_TOTAL_COUNT, 32'd40, '1);
				rchk(`OFS_ERROR_COUNT, 32'd1, '1);
				lk_u.send(poly_e'(p), 8, 1'b0, -1, -1);
				rchk(`OFS_TOTAL_COUNT, 32'd40, '1);
				rchk(`OFS_RESULT_INFO, 32'h7b, 32'h7f);
			end
		end
		// Inverted data loads a wrong start: 33 of 64 bits fail, result discarded
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_TOTAL_LIMIT, 32'd64);
		wr(`OFS_ERROR_LIMIT, 32'd64);
		wr(`OFS_STATUS, 32'h7);
		wr(`OFS_MASK, 32'h1);
		chk1(irq, 1'b0);
		wr(`OFS_CTRL, 32'h1);
		lk_u.send(POLY_PN9, 73, 1'b1, -1, -1);
		chk1(irq, 1'b1);
		rchk(`OFS_ERROR_COUNT, 32'd33, '1);
		rchk(`OFS_TOTAL_COUNT, 32'd64, '1);
		rchk(`OFS_RESULT_INFO, 32'hc3, 32'hcf);
		rchk(`OFS_STATUS, 32'h7, '1);
		wr(`OFS_MASK, 32'h0);
		chk1(irq, 1'b0);
		wr(`OFS_MASK, 32'h1);
		chk1(irq, 1'b1);
		wr(`OFS_STATUS, 32'h1);
		chk1(irq, 1'b0);
		// Integrating run across a sequence break bridged by restart
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_TOTAL_LIMIT, 32'd40);
		wr(`OFS_ERROR_LIMIT, `ERROR_LIMIT_RST);
		wr(`OFS_CTRL, 32'h41);
		lk_u.send(POLY_PN9, 19, 1'b0, -1, -1);
		lk_u.restart_seq();
		lk_u.send(POLY_PN9, 39, 1'b0, -1, -1);
		rchk(`OFS_TOTAL_COUNT, 32'd40, '1);
		rchk(`OFS_ERROR_COUNT, 32'd0, '1);
		// Mode store request, then a power cycle without the stored mode
		chk1(mode_store_req, 1'b0);
		wr(`OFS_CTRL, 32'h80);
		chk1(mode_store_req, 1'b1);
		@(posedge clk_sys);
		mode_stored <= 1'b0;
		rst_b       <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		rchk(`OFS_RESULT_INFO, 32'h0, 32'h40);
		chk1(mode_store_req, 1'b0);
		wr(`OFS_CTRL, 32'h1);
		lk_u.send(POLY_PN9, 20, 1'b0, -1, -1);
		rchk(`OFS_TOTAL_COUNT, 32'h0, '1);
		test_done();
	end
endmodule

bind prbs_bit_error_checker prbs_bit_error_checker_sva sva_u (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.bit_clk_in(bit_clk_in), .data_in(data_in),
	.data_valid_qualifier(data_valid_qualifier),
	.sequence_restart_input(sequence_restart_input), .mode_stored(mode_stored),
	.mode_store_req(mode_store_req));
